// ===== acc_pkg.sv
// package for the converter control and compare block
`default_nettype none
package acc_pkg;

  // ==========================================================================
  // register map (APB byte addresses)
  localparam logic [11:0] CTRL_IDX      = 12'h093;
  localparam logic [11:0] CTRL_ADDR     = 12'h24C;  // four times the index
  localparam logic [11:0] VALUE_ADDR    = 12'h250;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h254;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h258;
  localparam logic [11:0] POWER_ADDR    = 12'h25C;

  // ==========================================================================
  // control register fields
  localparam int ENABLE_BIT  = 7;
  localparam int DONE_BIT    = 6;
  localparam int CMP_EN_BIT  = 5;
  localparam int REF_SEL_BIT = 4;
  localparam int CHAN_HI     = 3;
  localparam int CHAN_LO     = 1;
  localparam int GO_BIT      = 0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [9:0] VALUE_RESET = 10'h000;

  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CMP_BIT  = 1;

  // ==========================================================================
  // core timing: sample cycles plus twelve conversion steps
  localparam logic [4:0] SAMPLE_CYCLES = 5'h02;
  localparam logic [4:0] CONV_CYCLES   = 5'h0C;

  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_SAMPLE = 2'b01,
    ACC_CONV   = 2'b10
  } acc_state_type;

  // request to the analogue core
  typedef struct packed {
    logic       power;
    logic       ext_ref;
    logic [7:0] chan_onehot;
    logic       sample;
  } acc_core_req_type;

endpackage : acc_pkg
`default_nettype wire

// ===== acc_seq.sv
// conversion sequencer: sample then convert, with abort
`default_nettype none
module acc_seq (
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  // control
  input  wire logic                    start,
  input  wire logic                    abort,
  // status
  output acc_pkg::acc_state_type       state,
  output logic                         done
);

  acc_pkg::acc_state_type state_q;
  logic [4:0]             cnt_q;

  assign state = state_q;

  // ==========================================================================
  // sequencer; done is a one-cycle pulse in the cycle after the last conversion step
  always_ff @(posedge CLK) begin
    if (SYS_RST || abort) begin
      state_q <= acc_pkg::ACC_IDLE;
      cnt_q   <= 5'h00;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        acc_pkg::ACC_IDLE: begin
          cnt_q <= 5'h00;
          if (start) begin
            state_q <= acc_pkg::ACC_SAMPLE;
          end
        end
        acc_pkg::ACC_SAMPLE: begin
          if (cnt_q == acc_pkg::SAMPLE_CYCLES - 5'h01) begin
            cnt_q   <= 5'h00;
            state_q <= acc_pkg::ACC_CONV;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        acc_pkg::ACC_CONV: begin
          if (cnt_q == acc_pkg::CONV_CYCLES - 5'h01) begin
            cnt_q   <= 5'h00;
            done    <= 1'b1;
            state_q <= acc_pkg::ACC_IDLE;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: begin
          state_q <= acc_pkg::ACC_IDLE;
        end
      endcase
    end
  end

endmodule // acc_seq
`default_nettype wire

// ===== acc_top.sv
// converter control register, compare logic and APB slave
`default_nettype none
module acc_top (
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  // apb slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // analogue core
  output acc_pkg::acc_core_req_type    CORE_REQ,
  input  wire logic [9:0]              CORE_RESULT,
  // power mode
  input  wire logic                    POWER_DOWN,
  // interrupt and wake
  output logic                         IRQ,
  output logic                         WAKE
);

  // ==========================================================================
  // storage
  logic [7:0]             ctrl_q;
  logic [9:0]             value_q;
  logic [1:0]             stat_q;
  logic [1:0]             mask_q;
  logic [9:0]             res_s1_q;
  logic [9:0]             res_s2_q;
  logic                   pd_s1_q;
  logic                   pd_s2_q;
  logic                   busy;
  logic                   done;
  logic                   start;
  logic                   abort;
  logic                   wr_ctrl;
  logic                   cmp_hit;
  logic                   active;
  acc_pkg::acc_state_type seq_state;

  // decode of an APB address to one register address; callers add the access phase
  function automatic logic acc_hit(input logic [11:0] addr, input logic [11:0] want);
    acc_hit = (addr == want);
  endfunction

  // ==========================================================================
  // pin synchronisers (result and power-down come from another domain)
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      res_s1_q <= 10'h000;
      res_s2_q <= 10'h000;
      pd_s1_q  <= 1'b0;
      pd_s2_q  <= 1'b0;
    end else begin
      res_s1_q <= CORE_RESULT;
      res_s2_q <= res_s1_q;
      pd_s1_q  <= POWER_DOWN;
      pd_s2_q  <= pd_s1_q;
    end
  end

  // ==========================================================================
  // control strobes
  assign wr_ctrl = PSEL && PENABLE && PWRITE && acc_hit(PADDR, acc_pkg::CTRL_ADDR);
  // power-down shuts the converter; idle mode does not touch it
  assign active  = ctrl_q[acc_pkg::ENABLE_BIT] && !pd_s2_q;
  assign busy    = (seq_state != acc_pkg::ACC_IDLE);
  // start only from idle, so a repeated go write cannot restart a run
  assign start   = active && ctrl_q[acc_pkg::GO_BIT] && !busy;
  // a go clear, a disable or power-down ends the running conversion
  assign abort   = busy && (!active ||
                   (wr_ctrl && !PWDATA[acc_pkg::GO_BIT]));
  assign cmp_hit = done && ctrl_q[acc_pkg::CMP_EN_BIT]
                   && (res_s2_q > value_q);

  acc_seq u_seq (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .start   (start),
    .abort   (abort),
    .state   (seq_state),
    .done    (done)
  );

  // ==========================================================================
  // control register: go and done bits have hardware side effects
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q <= acc_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= PWDATA[7:0];
        // done can only be cleared by software, never set by it
        ctrl_q[acc_pkg::DONE_BIT] <= ctrl_q[acc_pkg::DONE_BIT]
                                     && PWDATA[acc_pkg::DONE_BIT];
      end
      if (done && !ctrl_q[acc_pkg::CMP_EN_BIT]) begin
        ctrl_q[acc_pkg::GO_BIT]   <= 1'b0;
        ctrl_q[acc_pkg::DONE_BIT] <= 1'b1;
      end
      if (cmp_hit) begin
        ctrl_q[acc_pkg::DONE_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // value register: compare value in compare mode, result otherwise
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      value_q <= acc_pkg::VALUE_RESET;
    end else if (done && !ctrl_q[acc_pkg::CMP_EN_BIT]) begin
      value_q <= res_s2_q;
    end else if (PSEL && PENABLE && PWRITE && acc_hit(PADDR, acc_pkg::VALUE_ADDR)) begin
      value_q <= PWDATA[9:0];
    end
  end

  // ==========================================================================
  // sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else begin
      if (PSEL && PENABLE && PWRITE && acc_hit(PADDR, acc_pkg::IRQ_MASK_ADDR)) begin
        mask_q <= PWDATA[1:0];
      end
      if (PSEL && PENABLE && PWRITE && acc_hit(PADDR, acc_pkg::IRQ_STAT_ADDR)) begin
        stat_q <= stat_q & ~PWDATA[1:0]
                  | {cmp_hit, done && !ctrl_q[acc_pkg::CMP_EN_BIT]};
      end else begin
        stat_q <= stat_q | {cmp_hit, done && !ctrl_q[acc_pkg::CMP_EN_BIT]};
      end
    end
  end

  // interrupt also raises while the done flag stands, until software clears it
  assign IRQ  = |(stat_q & mask_q) || ctrl_q[acc_pkg::DONE_BIT];
  assign WAKE = IRQ;

  // ==========================================================================
  // core request
  always_comb begin
    CORE_REQ             = '0;
    CORE_REQ.power       = active;
    CORE_REQ.ext_ref     = ctrl_q[acc_pkg::REF_SEL_BIT];
    CORE_REQ.chan_onehot = 8'h01 << ctrl_q[acc_pkg::CHAN_HI:acc_pkg::CHAN_LO];
    // the shared pin is the reference, so channel 3 is not connected
    if (ctrl_q[acc_pkg::REF_SEL_BIT]) begin
      CORE_REQ.chan_onehot[3] = 1'b0;
    end
    CORE_REQ.sample      = (seq_state == acc_pkg::ACC_SAMPLE);
  end

  // ==========================================================================
  // apb read data, registered; zero-wait answer
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        acc_pkg::CTRL_ADDR:     PRDATA <= {24'h000000, ctrl_q};
        acc_pkg::VALUE_ADDR:    PRDATA <= {22'h000000, value_q};
        acc_pkg::IRQ_STAT_ADDR: PRDATA <= {30'h00000000, stat_q};
        acc_pkg::IRQ_MASK_ADDR: PRDATA <= {30'h00000000, mask_q};
        acc_pkg::POWER_ADDR:    PRDATA <= {30'h00000000, busy, pd_s2_q};
        default:                PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // checks
  done_sets_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    done && !ctrl_q[acc_pkg::CMP_EN_BIT] |=> ctrl_q[acc_pkg::DONE_BIT]
    ) else $error("done flag not set after conversion");
  go_self_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    done && !ctrl_q[acc_pkg::CMP_EN_BIT] && !wr_ctrl |=> !ctrl_q[acc_pkg::GO_BIT]
    ) else $error("go bit did not clear in normal mode");
  flag_holds_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    $fell(ctrl_q[acc_pkg::DONE_BIT]) |-> $past(wr_ctrl)
    ) else $error("done flag cleared without a write");
  abort_idles_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    abort |=> seq_state == acc_pkg::ACC_IDLE
    ) else $error("abort did not stop the conversion");
  result_load_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    done && !ctrl_q[acc_pkg::CMP_EN_BIT] |=> value_q == $past(res_s2_q)
    ) else $error("result not loaded with done");
  power_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !ctrl_q[acc_pkg::ENABLE_BIT] |-> !CORE_REQ.power
    ) else $error("core powered while disabled");
  no_restart_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    seq_state == acc_pkg::ACC_CONV && !abort ##1 seq_state == acc_pkg::ACC_CONV
    |-> $past(u_seq.cnt_q) + 5'h01 == u_seq.cnt_q
    ) else $error("running conversion restarted");
  cmp_keeps_go_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    done && ctrl_q[acc_pkg::CMP_EN_BIT] && !wr_ctrl |=> ctrl_q[acc_pkg::GO_BIT]
    ) else $error("go bit cleared in compare mode");

endmodule // acc_top
`default_nettype wire

// ===== acc_core_model.sv
// behavioural model of the analogue multiplexer and converter core
`default_nettype none
module acc_core_model (
  // clock and reset
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  // request from the control block
  input  wire acc_pkg::acc_core_req_type core_req,
  // analogue level seen on every input
  input  wire logic [9:0]                level,
  // converted value
  output logic      [9:0]                result
);
  logic [2:0] chan_idx;

  // ==========================================================================
  // one-hot channel back to its number
  always_comb begin
    chan_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (core_req.chan_onehot[i]) begin
        chan_idx = 3'(i);
      end
    end
  end

  // sample on request; unpowered output toggles so stale data never looks valid
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      result <= 10'h000;
    end else if (!core_req.power) begin
      result <= ~result;
    end else if (core_req.sample) begin
      result <= level ^ {7'h00, chan_idx} ^ (core_req.ext_ref ? 10'h200 : 10'h000);
    end
  end
endmodule  // acc_core_model
`default_nettype wire

// ===== tb_acc_top.sv
// self-checking testbench for the converter control block
`default_nettype none
module tb_acc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      CLK, SYS_RST, psel, penable, pwrite, pwr_dn;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, rd;
  logic [9:0]                level;
  wire logic [31:0]          prdata;
  wire logic                 pready, pslverr, irq, wake;
  wire logic [9:0]           core_res;
  wire acc_pkg::acc_core_req_type core_req;
  int                        n_errors, cmp_count;

  acc_top u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CORE_REQ(core_req), .CORE_RESULT(core_res), .POWER_DOWN(pwr_dn),
    .IRQ(irq), .WAKE(wake));
  acc_core_model u_core (.CLK(CLK), .SYS_RST(SYS_RST), .core_req(core_req),
    .level(level), .result(core_res));

  // ==========================================================================
  // clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK);
    penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge CLK);
      if (pready === 1'b1) break;
    end
    if (n == 8) begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    int n;
    {psel, penable, pwrite, pwr_dn} = 4'h0;
    {paddr, pwdata} = '0;
    level = 10'h155;
    n_errors = 0;
    cmp_count = 0;
    SYS_RST = 1'b1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    // reset values and an unmapped place
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(1'b1, 12'h300, 32'hFFFF_FFFF);
    apb(1'b0, 12'h300, 32'h0);
    chk("unmapped", 32'h0000_0000, rd);
    chk("no slave error", 32'h0, 32'(pslverr));
    chk("power off", 32'h0, 32'(core_req.power));
    $display("test reset done");
    // every channel code with both references
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, acc_pkg::CTRL_ADDR, 32'h80 | (r << 4) | (c << 1));
        @(negedge CLK);
        chk("onehot", (r == 1 && c == 3) ? 32'h0 : 32'h1 << c, 32'(core_req.chan_onehot));
        chk("ext ref", 32'(r), 32'(core_req.ext_ref));
        chk("power on", 32'h1, 32'(core_req.power));
      end
    end
    $display("test channels done");
    // normal conversion on channel 5, polled to the end
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8B);
    for (n = 0; n < 30; n++) begin
      apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    // a conversion that never ends is a mismatch, not a silent pass
    if (n == 30) n_errors++;
    chk("ctrl done", 32'hCA, rd);
    apb(1'b0, acc_pkg::VALUE_ADDR, 32'h0);
    chk("result", 32'h150, rd);
    chk("irq done", 32'h1, 32'(irq));
    // interrupt: status, mask, clear
    apb(1'b0, acc_pkg::IRQ_STAT_ADDR, 32'h0);
    chk("stat done", 32'h1, rd & 32'h1);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8A);
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("done cleared", 32'h8A, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, acc_pkg::IRQ_MASK_ADDR, 32'h1);
    @(negedge CLK);
    chk("wake", 32'h1, 32'(wake));
    apb(1'b1, acc_pkg::IRQ_STAT_ADDR, 32'h3);
    @(negedge CLK);
    chk("irq clear", 32'h0, 32'(irq));
    $display("test conversion done");
    // a second go while running must not restart the count
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8B);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8B);
    repeat (13) @(posedge CLK);
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("no restart", 32'hCA, rd);
    // clearing go mid-conversion aborts it
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8A);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8B);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h8A);
    repeat (20) @(posedge CLK);
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("aborted", 32'h8A, rd);
    $display("test restart abort done");
    // compare mode on channel 2: result 0x157, one above then equal
    apb(1'b1, acc_pkg::VALUE_ADDR, 32'h156);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'hA5);
    repeat (40) @(posedge CLK);
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("cmp hit", 32'hE5, rd);
    apb(1'b0, acc_pkg::IRQ_STAT_ADDR, 32'h0);
    chk("stat cmp", 32'h2, rd & 32'h2);
    apb(1'b0, acc_pkg::VALUE_ADDR, 32'h0);
    chk("value kept", 32'h156, rd);
    apb(1'b1, acc_pkg::VALUE_ADDR, 32'h157);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'hA5);
    repeat (40) @(posedge CLK);
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("cmp equal", 32'hA5, rd);
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'hA4);
    repeat (20) @(posedge CLK);
    apb(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
    chk("cmp stop", 32'hA4, rd);
    $display("test compare done");
    // power-down and disable both switch the core off
    pwr_dn <= 1'b1;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk("pd power", 32'h0, 32'(core_req.power));
    apb(1'b0, acc_pkg::POWER_ADDR, 32'h0);
    chk("power status", 32'h1, rd);
    pwr_dn <= 1'b0;
    apb(1'b1, acc_pkg::CTRL_ADDR, 32'h00);
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk("disabled", 32'h0, 32'(core_req.power));
    $display("test power done");
    summarize();
  end
endmodule  // tb_acc_top
`default_nettype wire
